// ### rtl/event_stretcher.sv
`timescale 1ns/1ns
`include "indicator_params.svh"

module event_stretcher
    import indicator_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // event and timing
    input wire logic event_i,
    input wire logic ms_tick_i,
    input wire ms_count_t hold_ms_i,
    input wire logic bypass_i,
    // stretched level
    output logic level_o
);

    stretch_s q;
    stretch_s d;

    // hold each event for one blink period unless bypassed
    always_comb begin
        d = q;
        if (event_i) begin
            d.cnt = hold_ms_i; // [R13]
        end else if (ms_tick_i && q.cnt != '0) begin
            d.cnt = q.cnt - 10'h001;
        end
        d.level = bypass_i ? event_i : (event_i | (q.cnt != '0)); // [R10] [R13]
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_o = q.level;

endmodule // event_stretcher

// ### rtl/indicator_params.svh
`ifndef INDICATOR_PARAMS_SVH
`define INDICATOR_PARAMS_SVH

// register offsets
`define ADDR_SOURCE_SEL 5'h18
`define ADDR_POL_OVERRIDE 5'h19
`define ADDR_BLINK_STRETCH 5'h1a

// reset values and writable masks
`define SOURCE_SEL_RESET 16'h6000
`define POL_OVERRIDE_RESET 16'h4444
`define POL_OVERRIDE_WMASK 16'h7777
`define BLINK_STRETCH_RESET 3'h2
`define BLINK_STRETCH_WMASK 16'h0007

// field positions, per output nibble of the override register; bypass bit of the blink/stretch register
`define FORCE_EN_BIT 0
`define FORCE_VAL_BIT 1
`define POLARITY_BIT 2
`define BYPASS_BIT 2

// timing
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define BLINK_MS_20HZ 10'h032
`define BLINK_MS_10HZ 10'h064
`define BLINK_MS_5HZ 10'h0c8
`define BLINK_MS_2HZ 10'h1f4

// source select codes
`define SRC_LINK 4'h0
`define SRC_ACT 4'h1
`define SRC_TX 4'h2
`define SRC_RX 4'h3
`define SRC_COL 4'h4
`define SRC_1000 4'h5
`define SRC_100 4'h6
`define SRC_10 4'h7
`define SRC_10_100 4'h8
`define SRC_100_1000 4'h9
`define SRC_FDX 4'ha
`define SRC_LINK_BLINK 4'hb
`define SRC_ERR 4'hd
`define SRC_RX_ERR 4'he

`endif

// ### rtl/indicator_pkg.sv
package indicator_pkg;

    typedef logic [9:0] ms_count_t;

    typedef struct packed {
        ms_count_t cnt;
        logic level;
    } stretch_s;

    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] cfg2;
        logic [2:0] cfg3;
        logic [15:0] rdata;
        logic [3:0] strap_s1;
        logic [3:0] strap_s2;
        logic [1:0] strap_cnt;
        logic [13:0] ms_cnt;
        logic ms_tick;
        ms_count_t blink_cnt;
        logic blink;
        logic [3:0] pins;
    } ctl_s;

endpackage

// ### rtl/status_indicator_output_control.sv
// How it works
// R01: aux output polarity bit 14: 0 active low, 1 active high; reset 1 or strap.
// R02: aux force enable bit 12 drives aux output with value bit 13.
// R03: output two polarity bit 10: 0 active low, 1 active high; reset 1 or strap.
// R04: output two force enable bit 8 drives it with value bit 9.
// R05: output one polarity bit 6: 0 active low, 1 active high; reset 1 or strap.
// R06: output one force enable bit 4 drives it with value bit 5.
// R07: output zero polarity bit 2: 0 active low, 1 active high; reset 1 or strap.
// R08: output zero force enable bit 0 drives it with value bit 1.
// R09: blink rate field: 50, 100, 200 or 500 ms period; resets to 10b.
// R10: stretch bypass bit shows events unstretched; reset 0 stretches them.
// R11: four-bit source select per output; aux uses output zero encoding.
// R12: code b shows copper link, blinking at blink rate on activity.
// R13: polarity applies to normal and forced level; events held one blink period.
// R14: reserved bits read zero; writes to them ignored.
`timescale 1ns/1ns
`include "indicator_params.svh"

module status_indicator_output_control
    import indicator_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // polarity straps: zero, one, two, aux
    input wire logic [3:0] strap_polarity_i,
    // status from the link core
    input wire logic link_up_i,
    input wire logic copper_i,
    input wire logic speed_1000_i,
    input wire logic speed_100_i,
    input wire logic speed_10_i,
    input wire logic full_duplex_i,
    input wire logic tx_active_i,
    input wire logic rx_active_i,
    input wire logic collision_i,
    input wire logic tx_error_i,
    input wire logic rx_error_i,
    // indicator pins
    output logic indicator_zero_out_o,
    output logic indicator_one_out_o,
    output logic indicator_two_out_o,
    output logic aux_indicator_out_o
);

    ctl_s q;
    ctl_s d;
    ms_count_t period_ms;
    logic [5:0] events;
    logic [5:0] held;

    // blink period from the rate field
    always_comb begin
        case (q.cfg3[1:0]) // [R09]
            2'h0: period_ms = `BLINK_MS_20HZ;
            2'h1: period_ms = `BLINK_MS_10HZ;
            2'h2: period_ms = `BLINK_MS_5HZ;
            default: period_ms = `BLINK_MS_2HZ;
        endcase
    end

    // event stretching
    assign events = {rx_error_i, rx_error_i | tx_error_i, collision_i,
                     rx_active_i, tx_active_i, rx_active_i | tx_active_i};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_stretch
            event_stretcher u_stretch (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .event_i(events[gi]),
                .ms_tick_i(q.ms_tick),
                .hold_ms_i(period_ms),
                .bypass_i(q.cfg3[`BYPASS_BIT]), // [R10]
                .level_o(held[gi])
            );
        end
    endgenerate

    // normal level for a source code
    function automatic logic source_level(input logic [3:0] code, input logic [5:0] ev, input logic blink);
        logic lvl;
        lvl = 1'b0;
        case (code) // [R11]
            `SRC_LINK: lvl = link_up_i;
            `SRC_ACT: lvl = ev[0];
            `SRC_TX: lvl = ev[1];
            `SRC_RX: lvl = ev[2];
            `SRC_COL: lvl = ev[3];
            `SRC_1000: lvl = link_up_i & speed_1000_i;
            `SRC_100: lvl = link_up_i & speed_100_i;
            `SRC_10: lvl = link_up_i & speed_10_i;
            `SRC_10_100: lvl = link_up_i & (speed_10_i | speed_100_i);
            `SRC_100_1000: lvl = link_up_i & (speed_100_i | speed_1000_i);
            `SRC_FDX: lvl = full_duplex_i;
            `SRC_LINK_BLINK: lvl = link_up_i & copper_i & ~(ev[0] & blink); // [R12]
            `SRC_ERR: lvl = ev[4];
            `SRC_RX_ERR: lvl = ev[5];
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    always_comb begin
        logic [3:0] nib;
        logic lvl;
        d = q;
        nib = 4'h0;
        lvl = 1'b0;

        // strap sampling after reset release
        d.strap_s1 = strap_polarity_i;
        d.strap_s2 = q.strap_s1;
        if (q.strap_cnt != 2'h3) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
        end
        if (q.strap_cnt == 2'h2) begin
            for (int i = 0; i < 4; i++) begin
                d.cfg2[4 * i + `POLARITY_BIT] = q.strap_s2[i]; // [R01] [R03] [R05] [R07]
            end
        end

        // register writes
        if (wr_i) begin
            case (addr_i)
                `ADDR_SOURCE_SEL: d.sel = wdata_i;
                `ADDR_POL_OVERRIDE: d.cfg2 = wdata_i & `POL_OVERRIDE_WMASK; // [R14]
                `ADDR_BLINK_STRETCH: d.cfg3 = wdata_i[2:0]; // [R14]
                default: d.sel = q.sel;
            endcase
        end

        // register reads, data valid the next cycle only
        d.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `ADDR_SOURCE_SEL: d.rdata = q.sel;
                `ADDR_POL_OVERRIDE: d.rdata = q.cfg2 & `POL_OVERRIDE_WMASK; // [R14]
                `ADDR_BLINK_STRETCH: d.rdata = {13'h0000, q.cfg3}; // [R14]
                default: d.rdata = 16'h0000;
            endcase
        end

        // millisecond tick
        d.ms_tick = 1'b0;
        if (q.ms_cnt == 14'(MS_CYCLES - 1)) begin
            d.ms_cnt = 14'h0000;
            d.ms_tick = 1'b1;
        end else begin
            d.ms_cnt = q.ms_cnt + 14'h0001;
        end

        // blink phase toggles each half period
        if (q.ms_tick) begin
            if (q.blink_cnt >= (period_ms >> 1) - 10'h001) begin // [R09]
                d.blink_cnt = 10'h000;
                d.blink = ~q.blink;
            end else begin
                d.blink_cnt = q.blink_cnt + 10'h001;
            end
        end

        // pin levels: force overrides source, polarity applies to both
        for (int i = 0; i < 4; i++) begin
            nib = q.cfg2[4 * i +: 4];
            lvl = source_level(q.sel[4 * (i == 3 ? 3 : i) +: 4], held, q.blink); // [R11]
            if (nib[`FORCE_EN_BIT]) begin
                lvl = nib[`FORCE_VAL_BIT]; // [R02] [R04] [R06] [R08]
            end
            d.pins[i] = lvl ~^ nib[`POLARITY_BIT]; // [R01] [R03] [R05] [R07] [R13]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.sel <= `SOURCE_SEL_RESET;
            q.cfg2 <= `POL_OVERRIDE_RESET;
            q.cfg3 <= `BLINK_STRETCH_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign indicator_zero_out_o = q.pins[0];
    assign indicator_one_out_o = q.pins[1];
    assign indicator_two_out_o = q.pins[2];
    assign aux_indicator_out_o = q.pins[3];

    // checks
    a_aux_force: assert property (@(posedge clock_i) disable iff (rst_i) // [R02]
        q.cfg2[12] |=> aux_indicator_out_o == ($past(q.cfg2[13]) ~^ $past(q.cfg2[14])))
        else $error("aux force value not driven");

    a_two_force: assert property (@(posedge clock_i) disable iff (rst_i) // [R04]
        q.cfg2[8] |=> indicator_two_out_o == ($past(q.cfg2[9]) ~^ $past(q.cfg2[10])))
        else $error("output two force value not driven");

    a_one_force: assert property (@(posedge clock_i) disable iff (rst_i) // [R06]
        q.cfg2[4] |=> indicator_one_out_o == ($past(q.cfg2[5]) ~^ $past(q.cfg2[6])))
        else $error("output one force value not driven");

    a_zero_force: assert property (@(posedge clock_i) disable iff (rst_i) // [R08]
        q.cfg2[0] |=> indicator_zero_out_o == ($past(q.cfg2[1]) ~^ $past(q.cfg2[2])))
        else $error("output zero force value not driven");

    a_zero_polarity: assert property (@(posedge clock_i) disable iff (rst_i) // [R07]
        (!q.cfg2[0] && q.sel[3:0] == `SRC_LINK)
        |=> indicator_zero_out_o == ($past(link_up_i) ~^ $past(q.cfg2[2])))
        else $error("output zero polarity wrong");

    a_one_polarity: assert property (@(posedge clock_i) disable iff (rst_i) // [R05]
        (!q.cfg2[4] && q.sel[7:4] == `SRC_LINK)
        |=> indicator_one_out_o == ($past(link_up_i) ~^ $past(q.cfg2[6])))
        else $error("output one polarity wrong");

    a_two_polarity: assert property (@(posedge clock_i) disable iff (rst_i) // [R03]
        (!q.cfg2[8] && q.sel[11:8] == `SRC_FDX)
        |=> indicator_two_out_o == ($past(full_duplex_i) ~^ $past(q.cfg2[10])))
        else $error("output two polarity wrong");

    a_aux_polarity: assert property (@(posedge clock_i) disable iff (rst_i) // [R01]
        (!q.cfg2[12] && q.sel[15:12] == `SRC_100)
        |=> aux_indicator_out_o == ($past(link_up_i & speed_100_i) ~^ $past(q.cfg2[14])))
        else $error("aux polarity wrong");

    a_blink_half: assert property (@(posedge clock_i) disable iff (rst_i) // [R09]
        $changed(q.blink) |-> $past(q.ms_tick) && $past(q.blink_cnt) >= ($past(period_ms) >> 1) - 10'h001)
        else $error("blink toggled off its half period");

    a_bypass_direct: assert property (@(posedge clock_i) disable iff (rst_i) // [R10]
        q.cfg3[2] |=> held[3] == $past(collision_i))
        else $error("bypassed event was stretched");

    a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i) // [R14]
        (rd_i && addr_i == `ADDR_POL_OVERRIDE) |=> (rdata_o & 16'h8888) == 16'h0000)
        else $error("reserved bits read nonzero");

endmodule // status_indicator_output_control

// ### verif/indicator_lamps.sv
`timescale 1ns/1ns

module indicator_lamps (
    // clock
    input wire logic clock_i,
    // pins from the block: zero, one, two, aux
    input wire logic [3:0] pin_i,
    // lamp state
    output logic [3:0] lit_o,
    output logic [15:0] flashes_o = 16'h0000
);
    logic [3:0] prev_q;

    // a lamp glows while its pin is high
    assign lit_o = pin_i;

    // count turn-on events of lamp zero
    always @(posedge clock_i) begin
        prev_q <= pin_i;
        if (pin_i[0] === 1'b1 && prev_q[0] === 1'b0) begin
            flashes_o <= flashes_o + 16'h0001;
        end
    end
endmodule // indicator_lamps

// ### verif/status_indicator_output_control_bench.sv
`timescale 1ns/1ns

module status_indicator_output_control_bench;
    import indicator_pkg::*;
    localparam int MS_CYC = 10;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic [3:0] strap_polarity_i = 4'hf;
    logic [10:0] st = 11'h000;
    logic [3:0] pins;
    logic [3:0] lit;
    logic [15:0] flashes;
    int err_count = 0;
    int comparisons = 0;
    int ms_tab [4] = '{50, 100, 200, 500};

    always #50 clock_i = ~clock_i;

    status_indicator_output_control #(.MS_CYCLES(MS_CYC)) i_status_indicator_output_control (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .strap_polarity_i(strap_polarity_i), .link_up_i(st[0]), .copper_i(st[1]),
        .speed_1000_i(st[2]), .speed_100_i(st[3]), .speed_10_i(st[4]), .full_duplex_i(st[5]),
        .tx_active_i(st[6]), .rx_active_i(st[7]), .collision_i(st[8]), .tx_error_i(st[9]),
        .rx_error_i(st[10]), .indicator_zero_out_o(pins[0]), .indicator_one_out_o(pins[1]),
        .indicator_two_out_o(pins[2]), .aux_indicator_out_o(pins[3]));

    indicator_lamps i_indicator_lamps (.clock_i(clock_i), .pin_i(pins), .lit_o(lit), .flashes_o(flashes));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
        repeat (3) @(negedge clock_i);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        check(rdata_o, exp);
    endtask

    task automatic set_st(input logic [10:0] v);
        @(posedge clock_i);
        st <= v;
        repeat (4) @(negedge clock_i);
    endtask

    task automatic measure(output int n);
        logic [15:0] f;
        f = flashes;
        n = 0;
        while (flashes === f) begin
            @(negedge clock_i);
            n++;
            if (n > 12000) begin
                check(16'h0000, 16'h0001);
                print_verdict();
            end
        end
    endtask

    task automatic t_regs();
        rdchk(5'h18, 16'h6000);
        rdchk(5'h19, 16'h4444);
        rdchk(5'h1a, 16'h0002);
        wr(5'h19, 16'hffff);
        rdchk(5'h19, 16'h7777);
        wr(5'h1a, 16'hffff);
        rdchk(5'h1a, 16'h0007);
        wr(5'h1b, 16'hffff);
        rdchk(5'h1b, 16'h0000);
        wr(5'h19, 16'h4444);
        wr(5'h1a, 16'h0002);
    endtask

    task automatic t_sources();
        logic [15:0] mask;
        mask = 16'h0741;
        set_st(11'h029);
        for (int c = 0; c < 16; c++) begin
            wr(5'h18, {4{c[3:0]}});
            check({15'h0000, lit[0]}, {15'h0000, mask[c]});
            check({15'h0000, lit[1]}, {15'h0000, mask[c]});
            check({15'h0000, lit[2]}, {15'h0000, mask[c]});
            check({15'h0000, lit[3]}, {15'h0000, mask[c]});
        end
    endtask

    task automatic t_force();
        logic [3:0] nib;
        wr(5'h18, 16'h0000);
        set_st(11'h000);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 8; k++) begin
                nib = {1'b0, k[2:0]};
                wr(5'h19, 16'(nib) << (4 * i));
                check({15'h0000, lit[i]}, {15'h0000, ~((k[0] & k[1]) ^ k[2])});
            end
        end
        wr(5'h19, 16'h4444);
    endtask

    task automatic t_stretch();
        int highs;
        highs = 0;
        wr(5'h18, 16'h0001);
        wr(5'h1a, 16'h0004);
        @(posedge clock_i);
        st <= 11'h040;
        @(posedge clock_i);
        st <= 11'h000;
        repeat (20) begin
            @(negedge clock_i);
            highs += int'(lit[0]);
        end
        check(16'(highs), 16'h0001);
        wr(5'h1a, 16'h0000);
        repeat (700) @(negedge clock_i);
        check({15'h0000, lit[0]}, 16'h0000);
        set_st(11'h040);
        @(posedge clock_i);
        st <= 11'h000;
        repeat (300) @(negedge clock_i);
        check({15'h0000, lit[0]}, 16'h0001);
        repeat (400) @(negedge clock_i);
        check({15'h0000, lit[0]}, 16'h0000);
    endtask

    task automatic t_blink();
        int n;
        wr(5'h18, 16'h000b);
        set_st(11'h003);
        check({15'h0000, lit[0]}, 16'h0001);
        set_st(11'h001);
        check({15'h0000, lit[0]}, 16'h0000);
        set_st(11'h083);
        for (int r = 0; r < 4; r++) begin
            wr(5'h1a, 16'(r));
            measure(n);
            measure(n);
            check(16'(n >= (ms_tab[r] - 1) * MS_CYC && n <= (ms_tab[r] + 1) * MS_CYC), 16'h0001);
        end
        set_st(11'h000);
    endtask

    task automatic t_strap();
        @(posedge clock_i);
        rst_i <= 1'b1;
        strap_polarity_i <= 4'ha;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (5) @(negedge clock_i);
        rdchk(5'h19, 16'h4040);
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (5) @(negedge clock_i);
        t_regs();
        t_sources();
        t_force();
        t_stretch();
        t_blink();
        t_strap();
        print_verdict();
    end
endmodule // status_indicator_output_control_bench
